// >>> usbcse_pkg.sv
package usbcse_pkg;
  // ==========================================================
  // device register map
  localparam logic [11:0] ADDR_CFG     = 12'hf39;
  localparam logic [11:0] ADDR_STAT    = 12'hf64;
  localparam logic [11:0] ADDR_EP_BASE = 12'hf26;
  localparam int          EP_COUNT     = 16;
  localparam int          EP_IDX_W     = 4;
  localparam int          REG_ADDR_W   = 12;
  localparam int          REG_DATA_W   = 8;
  // ==========================================================
  // configuration fields
  localparam int          CFG_EYE      = 7;
  localparam int          CFG_OEMON    = 6;
  localparam int          CFG_PULLUP   = 4;
  localparam int          CFG_TRDIS    = 3;
  localparam int          CFG_FULL_SPEED_SELECT     = 2;
  localparam int          CFG_PPB_LSB  = 0;
  localparam logic [7:0]  CFG_RESET    = 8'h00;
  localparam logic [7:0]  CFG_WMASK    = 8'hdf;
  // ==========================================================
  // endpoint control fields
  localparam int          EP_BITS      = 5;
  localparam int          EP_HSHK      = 4;
  localparam int          EP_CONDIS    = 3;
  localparam int          EP_OUTEN     = 2;
  localparam int          EP_INEN      = 1;
  localparam int          EP_STALL     = 0;
  localparam logic [4:0]  EP_RESET     = 5'h00;
  // ==========================================================
  // status entry: {endpoint, direction, bank}
  localparam int          STAT_W       = 6;
  localparam int          FIFO_DEPTH   = 4;
  typedef enum logic [1:0] {
    USBCSE_PPB_OFF   = 2'b00,
    USBCSE_PPB_OUT0  = 2'b01,
    USBCSE_PPB_ALL   = 2'b10,
    USBCSE_PPB_EP1UP = 2'b11
  } usbcse_ppb_t;
  typedef enum logic [1:0] {
    USBCSE_PID_OUT   = 2'b00,
    USBCSE_PID_IN    = 2'b01,
    USBCSE_PID_SETUP = 2'b10
  } usbcse_pid_t;
  typedef enum logic [1:0] {
    USBCSE_RESP_NONE = 2'b00,
    USBCSE_RESP_ACK  = 2'b01,
    USBCSE_RESP_NAK  = 2'b10,
    USBCSE_RESP_NOHS = 2'b11
  } usbcse_resp_t;
  // ==========================================================
  // timing: engine clock runs four times the bit rate
  localparam int          REF_CLK_KHZ  = 25000;
  localparam int          ENG_FS_KHZ   = 48000;
  localparam int          ENG_LS_KHZ   = 6000;
  localparam int          ENG_PER_BIT  = 4;
  localparam int          EYE_FS_RAW   = REF_CLK_KHZ * ENG_PER_BIT / ENG_FS_KHZ;
  localparam int          EYE_LS_RAW   = REF_CLK_KHZ * ENG_PER_BIT / ENG_LS_KHZ;
  localparam int          EYE_FS_CYC   = (EYE_FS_RAW < 1) ? 1 : EYE_FS_RAW;
  localparam int          EYE_LS_CYC   = (EYE_LS_RAW < 1) ? 1 : EYE_LS_RAW;
  localparam int          EYE_CNT_W    = 5;
  // ==========================================================
  // controller register map on the bus
  localparam int          AXI_ADDR_W   = 8;
  localparam logic [7:0]  AXI_ADDR     = 8'h00;
  localparam logic [7:0]  AXI_WDATA    = 8'h04;
  localparam logic [7:0]  AXI_CTRL     = 8'h08;
  localparam logic [7:0]  AXI_STATUS   = 8'h0c;
  localparam logic [7:0]  AXI_MODEN    = 8'h10;
  localparam int          CTRL_WR      = 0;
  localparam int          CTRL_RD      = 1;
  localparam int          CTRL_CLR     = 2;
  localparam int          ST_BUSY      = 0;
  localparam int          ST_FLAG      = 1;
  localparam int          ST_REFUSED   = 2;
  localparam int          ST_RDATA_LSB = 8;
  localparam logic [1:0]  AXI_OKAY     = 2'b00;
  localparam logic [1:0]  AXI_SLVERR   = 2'b10;
endpackage

// >>> usbcse_if.sv
`timescale 1ns/1ps
interface usbcse_if;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic        xfer_flag;
  logic        xfer_clr;
  modport dev (
    input  reg_addr, reg_wdata, reg_wr, reg_rd, xfer_clr,
    output reg_rdata, reg_rvalid, xfer_flag
  );
  modport fw (
    output reg_addr, reg_wdata, reg_wr, reg_rd, xfer_clr,
    input  reg_rdata, reg_rvalid, xfer_flag
  );
endinterface

// >>> usbcse_stat_fifo.sv
`timescale 1ns/1ps
module usbcse_stat_fifo #(
  parameter int W     = 6,
  parameter int DEPTH = 4
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         push,
  input  wire logic [W-1:0] push_data,
  input  wire logic         pop,
  output logic      [W-1:0] head,
  output logic              empty,
  output logic              full
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] CNT_FULL = (PW+1)'(DEPTH);
  logic [W-1:0] mem_r [DEPTH];
  logic [W-1:0] mem_nxt [DEPTH];
  logic [PW-1:0] rd_r, rd_nxt, wr_r, wr_nxt;
  logic [PW:0]   cnt_r, cnt_nxt;
  logic          do_push, do_pop;

  assign empty = (cnt_r == '0);
  assign full  = (cnt_r == CNT_FULL);
  assign head  = mem_r[rd_r];

  always_comb begin
    do_pop  = pop && !empty;
    do_push = push && (!full || do_pop);
    mem_nxt = mem_r;
    rd_nxt  = rd_r;
    wr_nxt  = wr_r;
    cnt_nxt = cnt_r;
    if (do_push) begin
      mem_nxt[wr_r] = push_data;
      wr_nxt        = (wr_r == PW'(DEPTH-1)) ? '0 : PW'(wr_r + 1'b1);
    end
    if (do_pop) begin
      rd_nxt = (rd_r == PW'(DEPTH-1)) ? '0 : PW'(rd_r + 1'b1);
    end
    if (do_push && !do_pop) begin
      cnt_nxt = (PW+1)'(cnt_r + 1'b1);
    end else if (do_pop && !do_push) begin
      cnt_nxt = (PW+1)'(cnt_r - 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      rd_r  <= '0;
      wr_r  <= '0;
      cnt_r <= '0;
    end else begin
      mem_r <= mem_nxt;
      rd_r  <= rd_nxt;
      wr_r  <= wr_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// >>> usbcse_device.sv
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - config bit 3 switches transceiver off
// - config bit 2 picks full or low speed
// - config bit 4 enables pull-up per speed
// - pull-up ignored while transceiver off
// - bit 6 monitors drive; forced active when off
// - two bits pick double buffering per endpoint
// - bit 7 repeats eye pattern until cleared
// - firmware prepares module before eye test
// - firmware freezes speed/pull-up/transceiver while enabled
// - status window shows head of four-entry queue
// - clearing flag advances; next entry re-raises quickly
// - empty queue after clear leaves flag low
// - full queue answers endpoint requests with NAK
// - entry: endpoint, direction, bank; ends zero
// - firmware reads status only while flag set
// - sixteen endpoints with identical control registers
// - endpoint bit 4 enables handshakes
// - bit 3 clear allows SETUP when bidirectional
// - bits 2 and 1 enable OUT and IN
// - engine sets stall bit until firmware clears
// - firmware keeps endpoint 0 control enabled
module usbcse_device #(
  parameter int FIFO_DEPTH = usbcse_pkg::FIFO_DEPTH
) (
  input  wire logic                REF_CLK,
  input  wire logic                RESETN,
  usbcse_if.dev                    BUS,
  input  wire logic                XFER_DONE,
  input  wire logic [3:0]          XFER_EP,
  input  wire logic                XFER_DIR_IN,
  input  wire logic                XFER_BANK_ODD,
  input  wire logic                TOKEN_REQ,
  input  wire logic [3:0]          TOKEN_EP,
  input  usbcse_pkg::usbcse_pid_t  TOKEN_PID,
  input  wire logic                STALL_SENT,
  input  wire logic [3:0]          STALL_EP,
  input  wire logic                LINE_DRIVING,
  output usbcse_pkg::usbcse_resp_t TOKEN_RESP,
  output logic                     TOKEN_DBUF,
  output logic                     TRANSCEIVER_ON,
  output logic                     FULL_SPEED,
  output logic                     PULLUP_DP,
  output logic                     PULLUP_DM,
  output logic                     LINE_DRIVE_N,
  output logic                     EYE_ACTIVE,
  output logic                     EYE_DP,
  output logic                     EYE_DM,
  output usbcse_pkg::usbcse_ppb_t  DOUBLE_BUF_MODE
);
  import usbcse_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic ep_hit(input logic [11:0] a);
    ep_hit = (a >= ADDR_EP_BASE) && (a < ADDR_EP_BASE + 12'(EP_COUNT));
  endfunction

  function automatic logic [3:0] ep_idx(input logic [11:0] a);
    logic [11:0] d;
    d      = a - ADDR_EP_BASE;
    ep_idx = d[EP_IDX_W-1:0];
  endfunction

  function automatic logic dbuf_used(input usbcse_ppb_t m, input logic [3:0] ep,
                                     input logic dir_in);
    case (m)
      USBCSE_PPB_OUT0:  dbuf_used = (ep == 4'h0) && !dir_in;
      USBCSE_PPB_ALL:   dbuf_used = 1'b1;
      USBCSE_PPB_EP1UP: dbuf_used = (ep != 4'h0);
      default:          dbuf_used = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // registers and status queue
  logic [7:0]         cfg_r, cfg_nxt;
  logic [EP_BITS-1:0] ep_r [EP_COUNT];
  logic [EP_BITS-1:0] ep_nxt [EP_COUNT];
  logic               flag_r, flag_nxt;
  logic [7:0]         rdata_r, rdata_nxt;
  logic               rvalid_r, rvalid_nxt;
  logic [STAT_W-1:0]  fifo_head, push_data;
  logic               fifo_empty, fifo_full, pop;
  usbcse_ppb_t        ppb;

  assign ppb       = usbcse_ppb_t'(cfg_r[CFG_PPB_LSB +: 2]);
  assign pop       = BUS.xfer_clr && flag_r;
  assign push_data = {XFER_EP, XFER_DIR_IN,
                      XFER_BANK_ODD && dbuf_used(ppb, XFER_EP, XFER_DIR_IN)};

  usbcse_stat_fifo #(
    .W     (STAT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (REF_CLK),
    .rst_n     (RESETN),
    .push      (XFER_DONE),
    .push_data (push_data),
    .pop       (pop),
    .head      (fifo_head),
    .empty     (fifo_empty),
    .full      (fifo_full)
  );

  always_comb begin
    cfg_nxt    = cfg_r;
    ep_nxt     = ep_r;
    rvalid_nxt = BUS.reg_rd;
    rdata_nxt  = 8'h00;
    if (BUS.reg_wr) begin
      if (BUS.reg_addr == ADDR_CFG) begin
        cfg_nxt = BUS.reg_wdata & CFG_WMASK;
      end else if (ep_hit(BUS.reg_addr)) begin
        ep_nxt[ep_idx(BUS.reg_addr)] = BUS.reg_wdata[EP_BITS-1:0];
      end
    end
    if (STALL_SENT) begin
      ep_nxt[STALL_EP][EP_STALL] = 1'b1;
    end
    if (BUS.reg_rd) begin
      if (BUS.reg_addr == ADDR_CFG) begin
        rdata_nxt = cfg_r;
      end else if (BUS.reg_addr == ADDR_STAT) begin
        rdata_nxt = {1'b0, fifo_head, 1'b0};
      end else if (ep_hit(BUS.reg_addr)) begin
        rdata_nxt = {3'h0, ep_r[ep_idx(BUS.reg_addr)]};
      end
    end
    // clear drops the flag one cycle; a waiting entry raises it next cycle
    if (pop) begin
      flag_nxt = 1'b0;
    end else begin
      flag_nxt = flag_r || !fifo_empty;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cfg_r <= CFG_RESET;
      for (int i = 0; i < EP_COUNT; i++) begin
        ep_r[i] <= EP_RESET;
      end
      flag_r   <= 1'b0;
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      cfg_r    <= cfg_nxt;
      ep_r     <= ep_nxt;
      flag_r   <= flag_nxt;
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign BUS.reg_rdata  = rdata_r;
  assign BUS.reg_rvalid = rvalid_r;
  assign BUS.xfer_flag  = flag_r;

  // ==========================================================
  // token answers
  usbcse_resp_t       resp_r, resp_nxt;
  logic               dbuf_r, dbuf_nxt;
  logic [EP_BITS-1:0] tok_ep;
  logic               tok_ok;

  always_comb begin
    tok_ep   = ep_r[TOKEN_EP];
    resp_nxt = USBCSE_RESP_NONE;
    dbuf_nxt = 1'b0;
    case (TOKEN_PID)
      USBCSE_PID_OUT:   tok_ok = tok_ep[EP_OUTEN];
      USBCSE_PID_IN:    tok_ok = tok_ep[EP_INEN];
      USBCSE_PID_SETUP: tok_ok = tok_ep[EP_OUTEN] && tok_ep[EP_INEN]
                                 && !tok_ep[EP_CONDIS];
      default:          tok_ok = 1'b0;
    endcase
    if (TOKEN_REQ && tok_ok) begin
      dbuf_nxt = dbuf_used(ppb, TOKEN_EP, TOKEN_PID == USBCSE_PID_IN);
      if (fifo_full) begin
        resp_nxt = USBCSE_RESP_NAK;
      end else if (tok_ep[EP_HSHK]) begin
        resp_nxt = USBCSE_RESP_ACK;
      end else begin
        resp_nxt = USBCSE_RESP_NOHS;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      resp_r <= USBCSE_RESP_NONE;
      dbuf_r <= 1'b0;
    end else begin
      resp_r <= resp_nxt;
      dbuf_r <= dbuf_nxt;
    end
  end

  assign TOKEN_RESP = resp_r;
  assign TOKEN_DBUF = dbuf_r;

  // ==========================================================
  // line control and eye pattern
  logic [EYE_CNT_W-1:0] cnt_r, cnt_nxt, eye_div;
  logic phase_r, phase_nxt;
  logic xon_r, xon_nxt, fs_r, fs_nxt, pdp_r, pdp_nxt, pdm_r, pdm_nxt;
  logic oen_r, oen_nxt, eact_r, eact_nxt, edp_r, edp_nxt, edm_r, edm_nxt;
  usbcse_ppb_t ppb_r;
  logic trdis, eye, fs;

  always_comb begin
    trdis    = cfg_r[CFG_TRDIS];
    eye      = cfg_r[CFG_EYE];
    fs       = cfg_r[CFG_FULL_SPEED_SELECT];
    eye_div  = fs ? EYE_CNT_W'(EYE_FS_CYC) : EYE_CNT_W'(EYE_LS_CYC);
    cnt_nxt  = '0;
    phase_nxt = 1'b0;
    // both speeds start with D- high: J at low speed, K at full speed
    if (eye) begin
      if (cnt_r == EYE_CNT_W'(eye_div - 1'b1)) begin
        phase_nxt = !phase_r;
      end else begin
        cnt_nxt   = EYE_CNT_W'(cnt_r + 1'b1);
        phase_nxt = phase_r;
      end
    end
    xon_nxt  = !trdis;
    fs_nxt   = fs;
    pdp_nxt  = cfg_r[CFG_PULLUP] && !trdis && fs;
    pdm_nxt  = cfg_r[CFG_PULLUP] && !trdis && !fs;
    oen_nxt  = trdis ? 1'b0 :
               (cfg_r[CFG_OEMON] ? !(LINE_DRIVING || eye) : 1'b1);
    eact_nxt = eye;
    edp_nxt  = eye && phase_nxt;
    edm_nxt  = eye && !phase_nxt;
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cnt_r   <= '0;
      phase_r <= 1'b0;
      xon_r   <= 1'b1;
      fs_r    <= 1'b0;
      pdp_r   <= 1'b0;
      pdm_r   <= 1'b0;
      oen_r   <= 1'b1;
      eact_r  <= 1'b0;
      edp_r   <= 1'b0;
      edm_r   <= 1'b0;
      ppb_r   <= USBCSE_PPB_OFF;
    end else begin
      cnt_r   <= cnt_nxt;
      phase_r <= phase_nxt;
      xon_r   <= xon_nxt;
      fs_r    <= fs_nxt;
      pdp_r   <= pdp_nxt;
      pdm_r   <= pdm_nxt;
      oen_r   <= oen_nxt;
      eact_r  <= eact_nxt;
      edp_r   <= edp_nxt;
      edm_r   <= edm_nxt;
      ppb_r   <= ppb;
    end
  end

  assign TRANSCEIVER_ON  = xon_r;
  assign FULL_SPEED      = fs_r;
  assign PULLUP_DP       = pdp_r;
  assign PULLUP_DM       = pdm_r;
  assign LINE_DRIVE_N    = oen_r;
  assign EYE_ACTIVE      = eact_r;
  assign EYE_DP          = edp_r;
  assign EYE_DM          = edm_r;
  assign DOUBLE_BUF_MODE = ppb_r;
endmodule

// >>> usbcse_fw.sv
`timescale 1ns/1ps
module usbcse_fw (
  input  wire logic       REF_CLK,
  input  wire logic       RESETN,
  usbcse_if.fw            BUS,
  input  wire logic [7:0] S_AXI_AWADDR,
  input  wire logic       S_AXI_AWVALID,
  output logic            S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0] S_AXI_WSTRB,
  input  wire logic       S_AXI_WVALID,
  output logic            S_AXI_WREADY,
  output logic [1:0]      S_AXI_BRESP,
  output logic            S_AXI_BVALID,
  input  wire logic       S_AXI_BREADY,
  input  wire logic [7:0] S_AXI_ARADDR,
  input  wire logic       S_AXI_ARVALID,
  output logic            S_AXI_ARREADY,
  output logic [31:0]     S_AXI_RDATA,
  output logic [1:0]      S_AXI_RRESP,
  output logic            S_AXI_RVALID,
  input  wire logic       S_AXI_RREADY,
  output logic            MODULE_EN
);
  import usbcse_pkg::*;

  // ==========================================================
  // bus slave and device sequencer
  logic        awg_r, awg_nxt, wg_r, wg_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
  logic [7:0]  awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt, rd32_r, rd32_nxt;
  logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;
  logic [11:0] addr_r, addr_nxt;
  logic [7:0]  wdat_r, wdat_nxt, dout_r, dout_nxt, shadow_r, shadow_nxt;
  logic [7:0]  rdat_r, rdat_nxt, d;
  logic        wr_r, wr_nxt, rd_r, rd_nxt, clr_r, clr_nxt, wait_r, wait_nxt;
  logic        moden_r, moden_nxt, ref_r, ref_nxt, busy;

  assign busy          = wait_r || wr_r || rd_r;
  assign S_AXI_AWREADY = !awg_r && !bv_r;
  assign S_AXI_WREADY  = !wg_r && !bv_r;
  assign S_AXI_ARREADY = !rv_r;

  always_comb begin
    awg_nxt = awg_r || (S_AXI_AWVALID && S_AXI_AWREADY);
    awa_nxt = (S_AXI_AWVALID && S_AXI_AWREADY) ? S_AXI_AWADDR : awa_r;
    wg_nxt  = wg_r || (S_AXI_WVALID && S_AXI_WREADY);
    wd_nxt  = (S_AXI_WVALID && S_AXI_WREADY) ? S_AXI_WDATA : wd_r;
    bv_nxt  = bv_r && !S_AXI_BREADY;
    br_nxt  = br_r;
    rv_nxt  = rv_r && !S_AXI_RREADY;
    rd32_nxt = rd32_r;
    rr_nxt  = rr_r;
    addr_nxt = addr_r;
    wdat_nxt = wdat_r;
    dout_nxt = dout_r;
    shadow_nxt = shadow_r;
    rdat_nxt = rdat_r;
    moden_nxt = moden_r;
    ref_nxt  = ref_r;
    wait_nxt = wait_r && !BUS.reg_rvalid;
    wr_nxt   = 1'b0;
    rd_nxt   = 1'b0;
    clr_nxt  = 1'b0;
    d        = wdat_r;
    if (wait_r && BUS.reg_rvalid) begin
      rdat_nxt = BUS.reg_rdata;
    end
    if (awg_r && wg_r && !bv_r) begin
      awg_nxt = 1'b0;
      wg_nxt  = 1'b0;
      bv_nxt  = 1'b1;
      br_nxt  = AXI_OKAY;
      if (!S_AXI_WSTRB[0]) begin
        br_nxt = AXI_OKAY;
      end else if (awa_r == AXI_ADDR) begin
        addr_nxt = wd_r[REG_ADDR_W-1:0];
      end else if (awa_r == AXI_WDATA) begin
        wdat_nxt = wd_r[REG_DATA_W-1:0];
      end else if (awa_r == AXI_MODEN) begin
        moden_nxt = wd_r[0];
      end else if (awa_r == AXI_CTRL) begin
        if (wd_r[CTRL_CLR] && BUS.xfer_flag) begin
          clr_nxt = 1'b1;
        end
        if (!busy && wd_r[CTRL_WR]) begin
          if (addr_r == ADDR_CFG) begin
            if (moden_r) begin
              d[CFG_FULL_SPEED_SELECT +: 3] = shadow_r[CFG_FULL_SPEED_SELECT +: 3];
            end else begin
              d[CFG_EYE] = 1'b0;
            end
            shadow_nxt = d;
          end else if (addr_r == ADDR_EP_BASE) begin
            d[EP_CONDIS] = 1'b0;
          end
          dout_nxt = d;
          wr_nxt   = 1'b1;
        end else if (!busy && wd_r[CTRL_RD]) begin
          if (addr_r == ADDR_STAT && !BUS.xfer_flag) begin
            ref_nxt = 1'b1;
          end else begin
            ref_nxt  = 1'b0;
            rd_nxt   = 1'b1;
            wait_nxt = 1'b1;
          end
        end
      end else if (awa_r != AXI_STATUS) begin
        br_nxt = AXI_SLVERR;
      end
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rv_nxt   = 1'b1;
      rr_nxt   = AXI_OKAY;
      rd32_nxt = 32'h0000_0000;
      if (S_AXI_ARADDR == AXI_ADDR) begin
        rd32_nxt[REG_ADDR_W-1:0] = addr_r;
      end else if (S_AXI_ARADDR == AXI_WDATA) begin
        rd32_nxt[REG_DATA_W-1:0] = wdat_r;
      end else if (S_AXI_ARADDR == AXI_MODEN) begin
        rd32_nxt[0] = moden_r;
      end else if (S_AXI_ARADDR == AXI_STATUS) begin
        rd32_nxt[ST_BUSY]    = busy;
        rd32_nxt[ST_FLAG]    = BUS.xfer_flag;
        rd32_nxt[ST_REFUSED] = ref_r;
        rd32_nxt[ST_RDATA_LSB +: REG_DATA_W] = rdat_r;
      end else if (S_AXI_ARADDR != AXI_CTRL) begin
        rr_nxt = AXI_SLVERR;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      awg_r <= 1'b0;
      wg_r  <= 1'b0;
      bv_r  <= 1'b0;
      rv_r  <= 1'b0;
      awa_r <= 8'h00;
      wd_r  <= 32'h0000_0000;
      rd32_r <= 32'h0000_0000;
      br_r  <= AXI_OKAY;
      rr_r  <= AXI_OKAY;
      addr_r <= 12'h000;
      wdat_r <= 8'h00;
      dout_r <= 8'h00;
      shadow_r <= CFG_RESET;
      rdat_r <= 8'h00;
      wr_r  <= 1'b0;
      rd_r  <= 1'b0;
      clr_r <= 1'b0;
      wait_r <= 1'b0;
      moden_r <= 1'b0;
      ref_r <= 1'b0;
    end else begin
      awg_r <= awg_nxt;
      wg_r  <= wg_nxt;
      bv_r  <= bv_nxt;
      rv_r  <= rv_nxt;
      awa_r <= awa_nxt;
      wd_r  <= wd_nxt;
      rd32_r <= rd32_nxt;
      br_r  <= br_nxt;
      rr_r  <= rr_nxt;
      addr_r <= addr_nxt;
      wdat_r <= wdat_nxt;
      dout_r <= dout_nxt;
      shadow_r <= shadow_nxt;
      rdat_r <= rdat_nxt;
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      clr_r <= clr_nxt;
      wait_r <= wait_nxt;
      moden_r <= moden_nxt;
      ref_r <= ref_nxt;
    end
  end

  assign S_AXI_BVALID  = bv_r;
  assign S_AXI_BRESP   = br_r;
  assign S_AXI_RVALID  = rv_r;
  assign S_AXI_RDATA   = rd32_r;
  assign S_AXI_RRESP   = rr_r;
  assign MODULE_EN     = moden_r;
  assign BUS.reg_addr  = addr_r;
  assign BUS.reg_wdata = dout_r;
  assign BUS.reg_wr    = wr_r;
  assign BUS.reg_rd    = rd_r;
  assign BUS.xfer_clr  = clr_r;
endmodule

// >>> usbcse_asserts.sv
`timescale 1ns/1ps
module usbcse_asserts
  import usbcse_pkg::*;
(
  input wire logic        REF_CLK,
  input wire logic        RESETN,
  input wire logic [11:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        xfer_flag,
  input wire logic        xfer_clr
);
  // ==========================================================
  // link and flag checks
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESETN);
  sequence s_read;
    reg_rd ##1 reg_rvalid;
  endsequence
  a_read_answer: assert property (reg_rd |-> s_read) else $error("read not answered");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray rvalid");
  a_strobe_excl: assert property (!(reg_wr && reg_rd)) else $error("two strobes");
  a_wr_pulse: assert property (reg_wr |=> !reg_wr) else $error("write strobe too long");
  a_rdata_idle: assert property (!reg_rvalid |-> reg_rdata == 8'h00) else $error("rdata idle");
  a_stat_ends: assert property (reg_rvalid && $past(reg_addr) == ADDR_STAT |->
    !reg_rdata[7] && !reg_rdata[0]) else $error("status end bits set");
  a_flag_pop: assert property (xfer_flag && xfer_clr |=> !xfer_flag)
    else $error("flag kept after clear");
  a_flag_keep: assert property (xfer_flag && !xfer_clr |=> xfer_flag)
    else $error("flag lost without clear");
endmodule

// >>> usb_config_status_endpoint_ctrl_tb.sv
`timescale 1ns/1ps
module usb_config_status_endpoint_ctrl_tb;
  import usbcse_pkg::*;
  logic        clk = 0, rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic        xd = 0, xdir = 0, xb = 0, tq = 0, ss = 0, ld = 0;
  logic        awr, wrd, bv, arr, rv, men, trx, fs, pdp, pdm, ldn, eya, edp, edm, db;
  logic [3:0]  xep = 0, tep = 0, sep = 0;
  logic [7:0]  awa = 0, ara = 0, v;
  logic [31:0] wd = 0, rdw, rdat;
  logic [1:0]  bresp, rresp, rrs;
  usbcse_pid_t tpid = USBCSE_PID_OUT;
  usbcse_resp_t tresp;
  usbcse_ppb_t ppb;
  int          bad_count = 0, n_tests = 0, cyc = 0, i;
  usbcse_if bus();
  usbcse_device usbcse_device_i (.REF_CLK(clk), .RESETN(rst_n), .BUS(bus.dev), .XFER_DONE(xd),
    .XFER_EP(xep), .XFER_DIR_IN(xdir), .XFER_BANK_ODD(xb), .TOKEN_REQ(tq), .TOKEN_EP(tep),
    .TOKEN_PID(tpid), .STALL_SENT(ss), .STALL_EP(sep), .LINE_DRIVING(ld), .TOKEN_RESP(tresp),
    .TOKEN_DBUF(db), .TRANSCEIVER_ON(trx), .FULL_SPEED(fs), .PULLUP_DP(pdp), .PULLUP_DM(pdm),
    .LINE_DRIVE_N(ldn), .EYE_ACTIVE(eya), .EYE_DP(edp), .EYE_DM(edm), .DOUBLE_BUF_MODE(ppb));
  usbcse_fw usbcse_fw_i (.REF_CLK(clk), .RESETN(rst_n), .BUS(bus.fw), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdw), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .MODULE_EN(men));
  usbcse_asserts usbcse_asserts_i (.REF_CLK(clk), .RESETN(rst_n), .reg_addr(bus.reg_addr),
    .reg_wr(bus.reg_wr), .reg_rd(bus.reg_rd), .reg_rdata(bus.reg_rdata),
    .reg_rvalid(bus.reg_rvalid), .xfer_flag(bus.xfer_flag), .xfer_clr(bus.xfer_clr));
  // ==========================================================
  // bus tasks
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while ((awv && !awr) || (wv && !wrd));
    do @(posedge clk); while (!bv);
  endtask
  task automatic axr(input logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    rdat = rdw;
    rrs = rresp;
  endtask
  task automatic devw(input logic [11:0] a, input logic [7:0] d);
    axw(AXI_ADDR, {20'h0, a});
    axw(AXI_WDATA, {24'h0, d});
    axw(AXI_CTRL, 32'h1);
    repeat (4) @(posedge clk);
  endtask
  task automatic devr(input logic [11:0] a);
    axw(AXI_ADDR, {20'h0, a});
    axw(AXI_CTRL, 32'h2);
    do axr(AXI_STATUS); while (rdat[ST_BUSY]);
    v = rdat[15:8];
  endtask
  task automatic tok(input logic [3:0] e, input usbcse_pid_t p, input usbcse_resp_t x);
    tep <= e;
    tpid <= p;
    tq <= 1'b1;
    @(posedge clk);
    tq <= 1'b0;
    #1 chk(tresp, x);
    chk(db, x && !e && p != USBCSE_PID_IN);
    @(posedge clk);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_cfg;
    chk({trx, ldn, ppb}, 4'b1100);
    devr(ADDR_CFG);
    chk(v, CFG_RESET);
    devw(ADDR_CFG, 8'h56);
    chk({trx, fs, pdp, pdm, ppb}, 6'b111010);
    ld <= 1'b1;
    repeat (2) @(posedge clk);
    chk(ldn, 1'b0);
    ld <= 1'b0;
    devw(ADDR_CFG, 8'h1b);
    chk({trx, pdp, pdm, ldn, ppb}, 6'b000011);
    devw(ADDR_CFG, 8'h11);
    chk({fs, pdp, pdm, ppb}, 5'b00101);
    axw(AXI_MODEN, 32'h1);
    chk(men, 1'b1);
    devw(ADDR_CFG, 8'h91);
    v[0] = edp;
    repeat (16) @(posedge clk);
    chk({eya, edp, edm}, {1'b1, ~v[0], v[0]});
    devw(ADDR_CFG, 8'h11);
    chk(eya, 1'b0);
    axw(AXI_MODEN, 32'h0);
    devw(ADDR_CFG, 8'h95);
    chk({eya, fs}, 2'b01);
    axw(AXI_MODEN, 32'h1);
    devw(ADDR_CFG, 8'h91);
    chk({eya, fs}, 2'b11);
    v[0] = edp;
    repeat (2) @(posedge clk);
    chk(edp, !v[0]);
    $display("config done");
  endtask
  task automatic t_queue;
    devw(ADDR_EP_BASE + 12'h3, 8'h16);
    xb <= 1'b1;
    for (i = 0; i < 4; i++) begin
      xep <= i[3:0];
      xdir <= i[0];
      xd <= 1'b1;
      @(posedge clk);
      xd <= 1'b0;
      @(posedge clk);
    end
    tok(4'h3, USBCSE_PID_OUT, USBCSE_RESP_NAK);
    for (i = 0; i < 4; i++) begin
      devr(ADDR_STAT);
      chk(v, {1'b0, i[3:0], i[0], i == 0, 1'b0});
      axw(AXI_CTRL, 32'h4);
    end
    repeat (4) @(posedge clk);
    axr(AXI_STATUS);
    chk(rdat[ST_FLAG], 1'b0);
    devr(ADDR_STAT);
    chk(rdat[ST_REFUSED], 1'b1);
    devw(ADDR_EP_BASE, 8'h1e);
    tok(4'h0, USBCSE_PID_SETUP, USBCSE_RESP_ACK);
    tok(4'h3, USBCSE_PID_IN, USBCSE_RESP_ACK);
    tok(4'h3, USBCSE_PID_SETUP, USBCSE_RESP_ACK);
    tok(4'h5, USBCSE_PID_OUT, USBCSE_RESP_NONE);
    devw(ADDR_EP_BASE + 12'h3, 8'h0e);
    tok(4'h3, USBCSE_PID_SETUP, USBCSE_RESP_NONE);
    tok(4'h3, USBCSE_PID_OUT, USBCSE_RESP_NOHS);
    $display("queue done");
  endtask
  task automatic t_stall;
    sep <= 4'h3;
    ss <= 1'b1;
    @(posedge clk);
    ss <= 1'b0;
    @(posedge clk);
    devr(ADDR_EP_BASE + 12'h3);
    chk(v, 8'h0f);
    devw(ADDR_EP_BASE + 12'h3, 8'h0e);
    devr(ADDR_EP_BASE + 12'h3);
    chk(v, 8'h0e);
    devw(ADDR_EP_BASE + 12'hf, 8'hff);
    devr(ADDR_EP_BASE + 12'hf);
    chk(v, 8'h1f);
    axr(8'h40);
    chk(rrs, AXI_SLVERR);
    axw(8'h40, 32'h0);
    chk(bresp, AXI_SLVERR);
    $display("stall done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========================================================
  // clock, timeout, sequence
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      stop_test;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_cfg;
    t_queue;
    t_stall;
    stop_test;
  end
endmodule
